// *** rtl/elcs_regs.sv ***
// Link configuration and static forwarding register bank on Wishbone.
`include "elcs_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module elcs_regs #(
  parameter int NUM_LINKS = 8,
  parameter int GAP_WIDTH = 11
) (
  // Clock and reset.
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  // Wishbone classic slave.
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [11:0]                   wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // Events from the link engines, one bit per link.
  input  wire logic [NUM_LINKS-1:0]          rx_overflow_i,
  input  wire logic [NUM_LINKS-1:0]          rx_bad_token_i,
  input  wire logic [NUM_LINKS-1:0]          credit_sent_i,
  input  wire logic [NUM_LINKS-1:0]          credit_got_i,
  // Controls to the link engines.
  output logic      [NUM_LINKS-1:0]          link_enable_o,
  output logic      [NUM_LINKS-1:0]          pin_grant_o,
  output logic      [NUM_LINKS-1:0]          five_wire_o,
  output logic      [NUM_LINKS-1:0]          may_transmit_o,
  output logic      [NUM_LINKS-1:0]          credit_handshake_request_o,
  output logic      [NUM_LINKS-1:0]          rx_resync_o,
  output logic [NUM_LINKS-1:0][GAP_WIDTH-1:0] sym_gap_m1_o,
  output logic [NUM_LINKS-1:0][GAP_WIDTH-1:0] tok_gap_m1_o,
  // Static forwarding, indexed by link letter A=0 to H=7.
  output logic      [NUM_LINKS-1:0]          static_en_o,
  output logic      [NUM_LINKS-1:0]          static_proc_o,
  output logic [NUM_LINKS-1:0][4:0]          static_chanend_o,
  // Interrupt.
  output logic                               irq_o
);

  ////////////////////////////////////////////////////////////////////////////

  // The letter order of the static registers is hard-wired for eight links,
  // and the interrupt layout packs two events per link into 16 bits.
  if (NUM_LINKS != elcs_pkg::ELCS_LINKS) begin : g_bad_links
    $error("elcs_regs: NUM_LINKS must be 8");
  end
  if (GAP_WIDTH != 11) begin : g_bad_gap
    $error("elcs_regs: GAP_WIDTH must be 11");
  end
  if (`ELCS_IRQ_CRED_LO + NUM_LINKS > 16) begin : g_bad_irq
    $error("elcs_regs: interrupt layout overflows 16 bits");
  end

  ////////////////////////////////////////////////////////////////////////////

  // Apply byte enables to a register word.
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // True when the index falls in the eight-word block at base.
  function automatic logic in_block(input logic [7:0] idx,
                                    input logic [7:0] base);
    return idx[7:3] == base[7:3];
  endfunction

  // Static register order C, D, A, B, G, H, E, F to link letter index.
  function automatic logic [2:0] static_link(input logic [2:0] reg_n);
    return reg_n ^ 3'h2;
  endfunction

  // Read image of a link configuration register.
  function automatic logic [31:0] cfg_word(
      input elcs_pkg::elcs_link_cfg_t c);
    logic [31:0] w;
    w = `ELCS_WORD_ZERO;
    w[`ELCS_CFG_ENABLE]     = c.enable;
    w[`ELCS_CFG_FIVE_WIRE]  = c.five_wire;
    w[`ELCS_CFG_RX_ERROR]   = c.rx_error;
    w[`ELCS_CFG_ISSUED]     = c.credit_issued;
    w[`ELCS_CFG_HAS_CREDIT] = c.has_credit;
    w[`ELCS_CFG_SYM_HI:`ELCS_CFG_SYM_LO] = c.sym_gap_m1;
    w[`ELCS_CFG_TOK_HI:`ELCS_CFG_TOK_LO] = c.tok_gap_m1;
    return w;
  endfunction

  // Read image of a static forwarding register.
  function automatic logic [31:0] static_word(
      input elcs_pkg::elcs_static_t s);
    logic [31:0] w;
    w = `ELCS_WORD_ZERO;
    w[`ELCS_ST_ENABLE] = s.enable;
    w[`ELCS_ST_PROC]   = s.dest_proc;
    w[`ELCS_ST_CHAN_HI:`ELCS_ST_CHAN_LO] = s.dest_chanend;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  elcs_pkg::elcs_state_t state_reg;
  elcs_pkg::elcs_state_t state_next;

  logic                 req;
  logic                 wr;
  logic                 rd;
  logic [7:0]           idx;
  logic                 idx_ok;
  logic [2:0]           sub;
  logic [2:0]           lnk;
  logic [31:0]          wword;
  logic                 hit_cfg;
  logic                 hit_static;
  logic                 hit_stat;
  logic                 hit_mask;
  logic [NUM_LINKS-1:0] err_evt;

  // Only the low 1 KiB of the bus window is decoded; any other address reads
  // as zero and ignores writes, yet is still acknowledged.
  assign idx        = wb_adr_i[9:2];
  assign idx_ok     = wb_adr_i[11:10] == 2'h0;
  assign sub        = idx[2:0];
  assign lnk        = static_link(sub);
  assign hit_cfg    = idx_ok & in_block(idx, `ELCS_CFG_IDX);
  assign hit_static = idx_ok & in_block(idx, `ELCS_STATIC_IDX);
  assign hit_stat   = idx_ok & (idx == `ELCS_IRQ_STAT_IDX);
  assign hit_mask   = idx_ok & (idx == `ELCS_IRQ_MASK_IDX);
  // The flag cannot tell an overflow from a bad token; software must resync.
  assign err_evt    = rx_overflow_i | rx_bad_token_i;
  // A request is taken only while ack is low, so a master that still holds
  // stb in the ack cycle does not start a second access.
  assign req        = wb_cyc_i & wb_stb_i & ~state_reg.ack;
  assign wr         = req & wb_we_i;
  assign rd         = req & ~wb_we_i;

  always_comb begin
    state_next           = state_reg;
    state_next.ack       = req;
    state_next.handshake = '0;
    state_next.rx_reset  = '0;
    wword                = `ELCS_WORD_ZERO;

    // Register writes; command bits only pulse for one cycle.
    if (wr && hit_cfg) begin
      wword = merge(cfg_word(state_reg.cfg[sub]), wb_dat_i, wb_sel_i);
      state_next.cfg[sub].enable     = wword[`ELCS_CFG_ENABLE];
      state_next.cfg[sub].five_wire  = wword[`ELCS_CFG_FIVE_WIRE];
      state_next.cfg[sub].sym_gap_m1 =
        wword[`ELCS_CFG_SYM_HI:`ELCS_CFG_SYM_LO];
      state_next.cfg[sub].tok_gap_m1 =
        wword[`ELCS_CFG_TOK_HI:`ELCS_CFG_TOK_LO];
      // A disabled link keeps no credit state from its last session.
      if (!wword[`ELCS_CFG_ENABLE]) begin
        state_next.cfg[sub].credit_issued = 1'b0;
        state_next.cfg[sub].has_credit    = 1'b0;
      end
      if (wb_sel_i[3] && wb_dat_i[`ELCS_CFG_HANDSHAKE]) begin
        state_next.handshake[sub]      = 1'b1;
        state_next.cfg[sub].has_credit = 1'b0;
      end
      if (wb_sel_i[2] && wb_dat_i[`ELCS_CFG_RX_RESET]) begin
        state_next.rx_reset[sub]     = 1'b1;
        state_next.cfg[sub].rx_error = 1'b0;
      end
    end
    if (wr && hit_static) begin
      wword = merge(static_word(state_reg.stat[lnk]), wb_dat_i, wb_sel_i);
      state_next.stat[lnk].enable       = wword[`ELCS_ST_ENABLE];
      state_next.stat[lnk].dest_proc    = wword[`ELCS_ST_PROC];
      state_next.stat[lnk].dest_chanend =
        wword[`ELCS_ST_CHAN_HI:`ELCS_ST_CHAN_LO];
    end
    if (wr && hit_mask) begin
      wword = merge({16'h0000, state_reg.irq_mask}, wb_dat_i, wb_sel_i);
      state_next.irq_mask = wword[15:0];
    end

    // Reads; the status register clears as it is read.
    state_next.rdata = `ELCS_WORD_ZERO;
    if (rd) begin
      if (hit_cfg) begin
        state_next.rdata = cfg_word(state_reg.cfg[sub]);
      end else if (hit_static) begin
        state_next.rdata = static_word(state_reg.stat[lnk]);
      end else if (hit_stat) begin
        state_next.rdata    = {16'h0000, state_reg.irq_stat};
        state_next.irq_stat = `ELCS_IRQ_RESET;
      end else if (hit_mask) begin
        state_next.rdata = {16'h0000, state_reg.irq_mask};
      end
    end

    // Link events come last so that a set beats a clear in one cycle.
    for (int l = 0; l < NUM_LINKS; l++) begin
      if (err_evt[l]) begin
        state_next.cfg[l].rx_error = 1'b1;
        state_next.irq_stat[`ELCS_IRQ_ERR_LO + l] = 1'b1;
      end
      if (credit_sent_i[l] && state_next.cfg[l].enable) begin
        state_next.cfg[l].credit_issued = 1'b1;
      end
      if (credit_got_i[l] && state_next.cfg[l].enable) begin
        state_next.cfg[l].has_credit = 1'b1;
        state_next.irq_stat[`ELCS_IRQ_CRED_LO + l] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int l = 0; l < elcs_pkg::ELCS_LINKS; l++) begin
        state_reg.cfg[l].enable        <= 1'b0;
        state_reg.cfg[l].five_wire     <= 1'b0;
        state_reg.cfg[l].rx_error      <= 1'b0;
        state_reg.cfg[l].credit_issued <= 1'b0;
        state_reg.cfg[l].has_credit    <= 1'b0;
        state_reg.cfg[l].sym_gap_m1    <= `ELCS_GAP_RESET;
        state_reg.cfg[l].tok_gap_m1    <= `ELCS_GAP_RESET;
        state_reg.stat[l].enable       <= 1'b0;
        state_reg.stat[l].dest_proc    <= 1'b0;
        state_reg.stat[l].dest_chanend <= `ELCS_CHAN_RESET;
      end
      state_reg.irq_stat  <= `ELCS_IRQ_RESET;
      state_reg.irq_mask  <= `ELCS_IRQ_RESET;
      state_reg.ack       <= 1'b0;
      state_reg.rdata     <= `ELCS_WORD_ZERO;
      state_reg.handshake <= '0;
      state_reg.rx_reset  <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  genvar g;
  generate
    for (g = 0; g < NUM_LINKS; g++) begin : g_link
      assign link_enable_o[g]    = state_reg.cfg[g].enable;
      // Overlapping links share pins; only an enabled link owns them.
      assign pin_grant_o[g]      = state_reg.cfg[g].enable;
      assign five_wire_o[g]      = state_reg.cfg[g].five_wire;
      assign may_transmit_o[g]   = state_reg.cfg[g].enable &
                                   state_reg.cfg[g].has_credit;
      assign sym_gap_m1_o[g]     = state_reg.cfg[g].sym_gap_m1;
      assign tok_gap_m1_o[g]     = state_reg.cfg[g].tok_gap_m1;
      assign static_en_o[g]      = state_reg.stat[g].enable;
      assign static_proc_o[g]    = state_reg.stat[g].dest_proc;
      assign static_chanend_o[g] = state_reg.stat[g].dest_chanend;
    end
  endgenerate

  assign credit_handshake_request_o = state_reg.handshake;
  assign rx_resync_o                = state_reg.rx_reset;
  assign wb_ack_o                   = state_reg.ack;
  assign wb_dat_o                   = state_reg.rdata;
  assign irq_o = |(state_reg.irq_stat & state_reg.irq_mask);

endmodule

`default_nettype wire

// *** rtl/elcs_defs.svh ***
// Register indices, field positions, reset values and bus constants.
`ifndef ELCS_DEFS_SVH
`define ELCS_DEFS_SVH

// Register indices; the byte address is four times the index.
`define ELCS_CFG_IDX        8'h80
`define ELCS_STATIC_IDX     8'ha0
`define ELCS_IRQ_STAT_IDX   8'hc0
`define ELCS_IRQ_MASK_IDX   8'hc1

// Link configuration fields.
`define ELCS_CFG_ENABLE     31
`define ELCS_CFG_FIVE_WIRE  30
`define ELCS_CFG_RX_ERROR   27
`define ELCS_CFG_ISSUED     26
`define ELCS_CFG_HAS_CREDIT 25
`define ELCS_CFG_HANDSHAKE  24
`define ELCS_CFG_RX_RESET   23
`define ELCS_CFG_SYM_HI     21
`define ELCS_CFG_SYM_LO     11
`define ELCS_CFG_TOK_HI     10
`define ELCS_CFG_TOK_LO     0

// Static forwarding fields.
`define ELCS_ST_ENABLE      31
`define ELCS_ST_PROC        8
`define ELCS_ST_CHAN_HI     4
`define ELCS_ST_CHAN_LO     0

// Interrupt status layout: rx errors low, credit arrivals high.
`define ELCS_IRQ_ERR_LO     0
`define ELCS_IRQ_CRED_LO    8

// Reset values.
`define ELCS_GAP_RESET      11'h000
`define ELCS_CHAN_RESET     5'h00
`define ELCS_IRQ_RESET      16'h0000
`define ELCS_WORD_ZERO      32'h0000_0000

`endif

// *** rtl/elcs_pkg.sv ***
// Types shared by the link configuration register bank.
package elcs_pkg;

  localparam int ELCS_LINKS = 8;

  typedef struct packed {
    logic        enable;
    logic        five_wire;
    logic        rx_error;
    logic        credit_issued;
    logic        has_credit;
    logic [10:0] sym_gap_m1;
    logic [10:0] tok_gap_m1;
  } elcs_link_cfg_t;

  typedef struct packed {
    logic       enable;
    logic       dest_proc;
    logic [4:0] dest_chanend;
  } elcs_static_t;

  typedef struct packed {
    elcs_link_cfg_t [ELCS_LINKS-1:0] cfg;
    elcs_static_t   [ELCS_LINKS-1:0] stat;
    logic           [15:0]           irq_stat;
    logic           [15:0]           irq_mask;
    logic                            ack;
    logic           [31:0]           rdata;
    logic           [ELCS_LINKS-1:0] handshake;
    logic           [ELCS_LINKS-1:0] rx_reset;
  } elcs_state_t;

endpackage

// *** tb/elcs_regs_monitor.sv ***
// Assertion checker for the link configuration register bank.
`timescale 1ns/10ps
`default_nettype none
module elcs_regs_chk #(
  parameter int NUM_LINKS = 8
) (
  // Clock, reset and bus.
  input wire logic                 clock_i,
  input wire logic                 rst_n_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  // Link side.
  input wire logic [NUM_LINKS-1:0] credit_got_i,
  input wire logic [NUM_LINKS-1:0] link_enable_o,
  input wire logic [NUM_LINKS-1:0] pin_grant_o,
  input wire logic [NUM_LINKS-1:0] may_transmit_o,
  input wire logic [NUM_LINKS-1:0] credit_handshake_request_o,
  input wire logic [NUM_LINKS-1:0] rx_resync_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK: assert property (s_take |=> s_pulse)
    else $error("bus ack missing or too long");
  AST_DAT0: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  AST_GRANT: assert property (pin_grant_o == link_enable_o)
    else $error("pin grant differs from enable");
  AST_HS: assert property (
    (|credit_handshake_request_o) |-> wb_ack_o && $past(wb_we_i))
    else $error("handshake pulse without write");
  AST_RS: assert property (
    (|rx_resync_o) |-> wb_ack_o ##1 rx_resync_o == '0)
    else $error("receiver reset pulse wrong");
  AST_HS_DROP: assert property (
    (credit_handshake_request_o & may_transmit_o &
     ~$past(credit_got_i)) == '0)
    else $error("credit kept after handshake");
  AST_CRED: assert property (
    (link_enable_o & $past(credit_got_i & link_enable_o) &
     ~may_transmit_o) == '0)
    else $error("returned credit not shown");
  AST_MAY: assert property ((may_transmit_o & ~link_enable_o) == '0)
    else $error("disabled link may transmit");
endmodule

bind elcs_regs elcs_regs_chk #(.NUM_LINKS(NUM_LINKS)) u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .credit_got_i(credit_got_i),
  .link_enable_o(link_enable_o), .pin_grant_o(pin_grant_o),
  .may_transmit_o(may_transmit_o),
  .credit_handshake_request_o(credit_handshake_request_o),
  .rx_resync_o(rx_resync_o));
`default_nettype wire

// *** tb/elcs_link_peer.sv ***
// Behavioural far-end switch that returns credit after a handshake.
`timescale 1ns/10ps
`default_nettype none
module elcs_link_peer (
  // Clock and reset.
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Handshake in, credit events out.
  input  wire logic [7:0] hs_i,
  input  wire logic [7:0] delay_i,
  output logic      [7:0] got_o
);
  logic [7:0] pend_reg;
  logic [7:0] cnt_reg;
  // One outstanding handshake at a time; a new one restarts the wait.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_reg <= 8'h00;
      cnt_reg <= 8'h00;
      got_o <= 8'h00;
    end else begin
      got_o <= 8'h00;
      if (|hs_i) begin
        pend_reg <= hs_i;
        cnt_reg <= delay_i;
      end else if (pend_reg != 8'h00) begin
        if (cnt_reg == 8'h00) begin
          got_o <= pend_reg;
          pend_reg <= 8'h00;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_elcs_regs.sv ***
// Self-checking bench for the link configuration register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_elcs_regs;
  logic             clock_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             cyc = 1'b0;
  logic             we = 1'b0;
  logic [11:0]      adr = 12'h000;
  logic [31:0]      wdat = 32'h0000_0000;
  logic [31:0]      rd, dat_o;
  logic [7:0]       ovf = 8'h00;
  logic [7:0]       bad = 8'h00;
  logic [7:0]       dly = 8'h03;
  logic [7:0]       snt = 8'h00;
  logic [7:0]       got, en, gr, fw, mt, hs, rs, se, sp;
  logic [7:0][10:0] sg, tg;
  logic [7:0][4:0]  sc;
  logic             ack, irq;
  int               err_count = 0;
  int               n_compared = 0;
  ////////////////////////////////////////
  initial forever #25 clock_i = ~clock_i;
  elcs_regs i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .rx_overflow_i(ovf), .rx_bad_token_i(bad), .credit_sent_i(snt),
    .credit_got_i(got), .link_enable_o(en), .pin_grant_o(gr),
    .five_wire_o(fw), .may_transmit_o(mt),
    .credit_handshake_request_o(hs), .rx_resync_o(rs),
    .sym_gap_m1_o(sg), .tok_gap_m1_o(tg), .static_en_o(se),
    .static_proc_o(sp), .static_chanend_o(sc), .irq_o(irq));
  elcs_link_peer i_peer (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .hs_i(hs), .delay_i(dly), .got_o(got));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clock_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {2'b00, i, 2'b00};
    wdat <= d;
    do begin
      @(posedge clock_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
    @(negedge clock_i);
  endtask
  task automatic rdchk(input logic [7:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0000_0000);
    chk(rd, e);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rdchk(8'h80 + i[7:0], 32'h0000_0000);
      rdchk(8'ha0 + i[7:0], 32'h0000_0000);
    end
    bus(1'b1, 8'hc1, 32'h0000_0820);
    bus(1'b1, 8'h83, 32'hffff_ffff);
    chk(en, 8'h08);
    chk(gr, 8'h08);
    chk(fw, 8'h08);
    chk({sg[3], tg[3]}, 32'h003f_ffff);
    repeat (40) if (mt[3] !== 1'b1) @(negedge clock_i);
    @(posedge clock_i);
    snt <= 8'h08;
    @(posedge clock_i);
    snt <= 8'h00;
    rdchk(8'h83, 32'hc63f_ffff);
    chk(irq, 1'b1);
    rdchk(8'hc0, 32'h0000_0800);
    chk(irq, 1'b0);
    dly <= 8'h14;
    bus(1'b1, 8'h83, 32'h8100_0000);
    chk(mt, 8'h00);
    rdchk(8'h83, 32'h8400_0000);
    repeat (40) if (mt[3] !== 1'b1) @(negedge clock_i);
    chk(mt, 8'h08);
    rdchk(8'hc0, 32'h0000_0800);
    chk(irq, 1'b0);
    @(posedge clock_i);
    ovf <= 8'h20;
    @(posedge clock_i);
    ovf <= 8'h00;
    rdchk(8'h85, 32'h0800_0000);
    chk(irq, 1'b1);
    bus(1'b1, 8'h85, 32'h0080_0000);
    rdchk(8'h85, 32'h0000_0000);
    @(posedge clock_i);
    bad <= 8'h20;
    @(posedge clock_i);
    bad <= 8'h00;
    rdchk(8'h85, 32'h0800_0000);
    rdchk(8'hc0, 32'h0000_0020);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'ha0 + i[7:0], {23'h40_0000, i[0], 3'h7, i[4:0]});
      chk({sp[i ^ 2], sc[i ^ 2]}, {i[0], i[4:0]});
      rdchk(8'ha0 + i[7:0], {23'h40_0000, i[0], 3'h0, i[4:0]});
    end
    chk(se, 8'hff);
    bus(1'b1, 8'h90, 32'hffff_ffff);
    rdchk(8'h90, 32'h0000_0000);
    bus(1'b1, 8'h83, 32'h0000_0000);
    chk(en | mt, 8'h00);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    chk(se, 8'h00);
    rdchk(8'ha2, 32'h0000_0000);
    wrap_up;
  end
endmodule
`default_nettype wire
